// *** inc/meter_ui_pkg.sv ***
// Purpose: Shared constants and types for the meter operator interface.
// Assumes: 100 MHz system clock, synchronous active-high reset.
// Notes:   Readings are signed display units; times derive from the clock rate.
package meter_ui_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 100_000_000;
    localparam int HOLD_ENTRY_S    = 2;                       // Choose key hold time
    localparam int SCROLL_S        = 4;                       // Auto scroll period
    localparam int DEBOUNCE_MS     = 10;
    localparam int REPEAT_MS       = 250;                     // Digit auto scroll period
    localparam int BLINK_MS        = 500;                     // Prompt alternation
    localparam int HOLD_ENTRY_CYC  = HOLD_ENTRY_S * CLK_HZ;
    localparam int SCROLL_CYC      = SCROLL_S * CLK_HZ;
    localparam int DEBOUNCE_CYC    = DEBOUNCE_MS * (CLK_HZ / 1000);
    localparam int REPEAT_CYC      = REPEAT_MS * (CLK_HZ / 1000);
    localparam int BLINK_CYC       = BLINK_MS * (CLK_HZ / 1000);
    localparam int SEC_CYC         = CLK_HZ;

    // ------------------------------------------------------------
    // Ranges and counts
    // ------------------------------------------------------------
    localparam logic signed [19:0] OFFSET_MAX  = 20'sd19999;
    localparam logic [7:0]         BAND_MAX    = 8'd199;
    localparam logic [13:0]        DELAY_MAX   = 14'd9999;
    localparam logic [3:0]         NUM_MODULES = 4'h4;
    localparam logic [3:0]         NUM_PARAMS  = 4'h4;
    localparam logic [3:0]         DIGIT_COUNT = 4'h5;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        VIEW_INPUT = 2'h0,
        VIEW_MAX   = 2'h1,
        VIEW_MIN   = 2'h2
    } view_t;

    typedef enum logic [3:0] {
        NO_FN                 = 4'h0,
        LOCK_FN               = 4'h1,
        CAPTURE_RESET_FN      = 4'h2,
        freeze_view_fn        = 4'h3,
        view_advance_fn       = 4'h4,
        intensity_step_fn     = 4'h5,
        backlight_toggle_fn   = 4'h6,
        transmit_request_fn   = 4'h7,
        transmit_and_clear_fn = 4'h8,
        OUT1_RESET_FN         = 4'h9,
        OUT2_RESET_FN         = 4'ha,
        BOTH_OUT_RESET_FN     = 4'hb
    } switch_fn_t;

    typedef enum logic [1:0] {
        MAX_TARGET          = 2'h0,
        MIN_TARGET          = 2'h1,
        both_capture_target = 2'h2,
        SHOWN_TARGET        = 2'h3
    } target_t;

    // Gray codes along display -> menu -> param -> edit
    typedef enum logic [1:0] {
        ST_DISPLAY = 2'b00,
        ST_MENU    = 2'b01,
        ST_PARAM   = 2'b11,
        ST_EDIT    = 2'b10
    } ui_state_t;

    typedef struct packed {
        logic       scroll_en;
        logic [1:0] filter_level;
        logic [7:0] filter_band;
        logic signed [19:0] offset;
        switch_fn_t fn;
        target_t    target;
        logic       max_en;
        logic       min_en;
        logic [13:0] max_delay;
        logic [13:0] min_delay;
        logic       locked;
    } cfg_t;

    typedef struct packed {
        logic out1_reset;
        logic out2_reset;
        logic transmit;
        logic intensity_up;
        logic color_toggle;
    } req_t;

endpackage

// *** src/meter_operator_interface.sv ***
// Purpose: Operator keys, menu walk, display filtering and user switch actions.
// Assumes: Inputs synchronous to clk_in; parameter store lies outside this block.
// Notes:   Parameter contents are held outside; this block walks the menu only.
`timescale 1ns/1ns
module meter_operator_interface
    import meter_ui_pkg::*;
#(
    parameter int HOLD_CYC   = HOLD_ENTRY_CYC,
    parameter int SCROLL_P   = SCROLL_CYC,
    parameter int DEB_CYC    = DEBOUNCE_CYC,
    parameter int REP_CYC    = REPEAT_CYC,
    parameter int BLK_CYC    = BLINK_CYC,
    parameter int SECOND_CYC = SEC_CYC
) (
    // Clock and reset
    input  wire logic               clk_in,
    input  wire logic               reset_in,
    input  wire logic               clk_en_in,
    // Operator keys and switch, active high keys, active low switch
    input  wire logic               choose_key_in,
    input  wire logic               clear_key_in,
    input  wire logic               external_switch_pin_n_in,
    // Configuration and reading
    input  wire cfg_t               cfg_in,
    input  wire logic               reading_valid_in,
    input  wire logic signed [19:0] reading_in,
    // Display
    output logic signed [19:0]      shown_value_out,
    output view_t                   view_out,
    output ui_state_t               ui_state_out,
    output logic                    prompt_phase_out,
    output logic [3:0]              module_out,
    output logic [3:0]              param_out,
    output logic [2:0]              digit_out,
    output logic                    digit_step_out,
    output logic                    choice_step_out,
    output logic                    store_out,
    output logic                    commit_out,
    output logic                    load_defaults_out,
    output logic                    reset_msg_out,
    output logic                    edit_numeric_in_unused_out,
    // Requests
    output req_t                    req_out
);

    // ------------------------------------------------------------
    // Debounce and edge detection
    // ------------------------------------------------------------
    logic [2:0] raw;
    logic [2:0] stable;
    logic [2:0] stable_d;
    logic [2:0] rise;
    assign raw  = {~external_switch_pin_n_in, clear_key_in, choose_key_in};
    assign rise = stable & ~stable_d;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_deb
            logic [23:0] cnt;
            // A level must hold for the full window before it is believed
            always_ff @(posedge clk_in) begin
                if (reset_in) begin
                    cnt       <= 24'h0;
                    stable[g] <= 1'b0;
                end else if (clk_en_in) begin
                    if (raw[g] == stable[g]) begin
                        cnt <= 24'h0;
                    end else if (cnt >= 24'(DEB_CYC - 1)) begin
                        cnt       <= 24'h0;
                        stable[g] <= raw[g];
                    end else begin
                        cnt <= cnt + 24'h1;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_in) begin
        if (reset_in) stable_d <= 3'h0;
        else if (clk_en_in) stable_d <= stable;
    end

    logic choose_press, clear_press, sw_edge, sw_active, boot_done;
    // Power-up chord is no press
    assign choose_press = rise[0] && boot_done;
    assign clear_press  = rise[1] && boot_done;
    assign sw_edge      = rise[2];
    assign sw_active    = stable[2];

    // ------------------------------------------------------------
    // Power-up defaults check
    // ------------------------------------------------------------
    logic [23:0] boot_cnt;
    // Debounced keys sampled only after the debounce window, never under reset
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            boot_done         <= 1'b0;
            boot_cnt          <= 24'h0;
            load_defaults_out <= 1'b0;
            reset_msg_out     <= 1'b0;
        end else if (clk_en_in) begin
            load_defaults_out <= 1'b0;
            if (!boot_done) begin
                boot_cnt <= boot_cnt + 24'h1;
                if (boot_cnt >= 24'(DEB_CYC + 1)) begin
                    boot_done <= 1'b1;
                    if (stable[0] && stable[1]) begin
                        load_defaults_out <= 1'b1;
                        reset_msg_out     <= 1'b1;
                    end
                end
            end else if (choose_press || clear_press) begin
                reset_msg_out <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Filter and offset
    // ------------------------------------------------------------
    logic signed [19:0] filtered;
    logic signed [20:0] adj, diff, mag;
    logic signed [20:0] next_filt;
    assign adj  = 21'(reading_in) + 21'(cfg_in.offset);
    assign diff = adj - 21'(filtered);
    assign mag  = diff[20] ? -diff : diff;
    always_comb begin
        unique case (cfg_in.filter_level)
            2'd0:    next_filt = adj;
            2'd1:    next_filt = 21'(filtered) + (diff >>> 2);
            2'd2:    next_filt = 21'(filtered) + (diff >>> 3);
            default: next_filt = 21'(filtered) + (diff >>> 4);
        endcase
        if (cfg_in.filter_band != 8'h0 && mag > 21'(cfg_in.filter_band)) begin
            next_filt = adj;
        end
    end
    always_ff @(posedge clk_in) begin
        if (reset_in) filtered <= 20'sh0;
        else if (clk_en_in && reading_valid_in) filtered <= 20'(next_filt);
    end

    // ------------------------------------------------------------
    // Capture values with delay
    // ------------------------------------------------------------
    logic signed [19:0] max_val, min_val;
    logic [13:0] max_sec, min_sec;
    logic [27:0] sec_cnt;
    logic        sec_tick;
    logic        sw_reset_fn, clr_max, clr_min;
    assign sec_tick = (sec_cnt >= 28'(SECOND_CYC - 1));
    always_ff @(posedge clk_in) begin
        if (reset_in) sec_cnt <= 28'h0;
        else if (clk_en_in) sec_cnt <= sec_tick ? 28'h0 : sec_cnt + 28'h1;
    end

    // Capture clears by switch edge (with assignment) or clear key on shown view
    assign sw_reset_fn = sw_edge && (cfg_in.fn == CAPTURE_RESET_FN
                         || cfg_in.fn == transmit_and_clear_fn);
    always_comb begin
        clr_max = 1'b0;
        clr_min = 1'b0;
        if (sw_reset_fn) begin
            clr_max = cfg_in.target == MAX_TARGET || cfg_in.target == both_capture_target
                      || (cfg_in.target == SHOWN_TARGET && view_out == VIEW_MAX);
            clr_min = cfg_in.target == MIN_TARGET || cfg_in.target == both_capture_target
                      || (cfg_in.target == SHOWN_TARGET && view_out == VIEW_MIN);
        end
        if (ui_state_out == ST_DISPLAY && clear_press) begin
            clr_max = clr_max || view_out == VIEW_MAX;
            clr_min = clr_min || view_out == VIEW_MIN;
        end
    end

    // Delay counts whole seconds spent beyond the present capture
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            max_val <= 20'sh0;
            min_val <= 20'sh0;
            max_sec <= 14'h0;
            min_sec <= 14'h0;
        end else if (clk_en_in) begin
            if (clr_max) begin
                max_val <= filtered;
                max_sec <= 14'h0;
            end else if (filtered <= max_val) begin
                max_sec <= 14'h0;
            end else if (max_sec >= cfg_in.max_delay) begin
                max_val <= filtered;
                max_sec <= 14'h0;
            end else if (sec_tick) begin
                max_sec <= max_sec + 14'h1;
            end
            if (clr_min) begin
                min_val <= filtered;
                min_sec <= 14'h0;
            end else if (filtered >= min_val) begin
                min_sec <= 14'h0;
            end else if (min_sec >= cfg_in.min_delay) begin
                min_val <= filtered;
                min_sec <= 14'h0;
            end else if (sec_tick) begin
                min_sec <= min_sec + 14'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Display view selection
    // ------------------------------------------------------------
    logic [31:0] scroll_cnt;
    logic        step_view;
    view_t       next_view;
    always_comb begin
        next_view = VIEW_INPUT;
        unique case (view_out)
            VIEW_INPUT: next_view = cfg_in.max_en ? VIEW_MAX
                                  : (cfg_in.min_en ? VIEW_MIN : VIEW_INPUT);
            VIEW_MAX:   next_view = cfg_in.min_en ? VIEW_MIN : VIEW_INPUT;
            default:    next_view = VIEW_INPUT;
        endcase
    end
    assign step_view = ui_state_out == ST_DISPLAY && (choose_press
                       || (sw_edge && cfg_in.fn == view_advance_fn)
                       || (cfg_in.scroll_en && scroll_cnt >= 32'(SCROLL_P - 1)));
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            view_out   <= VIEW_INPUT;
            scroll_cnt <= 32'h0;
        end else if (clk_en_in) begin
            scroll_cnt <= step_view ? 32'h0 : scroll_cnt + 32'h1;
            if (step_view) view_out <= next_view;
        end
    end

    // Hold freezes only the assigned view; other logic keeps running
    logic freeze;
    always_comb begin
        freeze = sw_active && cfg_in.fn == freeze_view_fn;
        unique case (cfg_in.target)
            MAX_TARGET:          freeze = freeze && view_out == VIEW_MAX;
            MIN_TARGET:          freeze = freeze && view_out == VIEW_MIN;
            both_capture_target: freeze = freeze && view_out != VIEW_INPUT;
            default:             freeze = freeze;
        endcase
    end
    // Same scale and point for every view: all use one unit domain
    always_ff @(posedge clk_in) begin
        if (reset_in) shown_value_out <= 20'sh0;
        else if (clk_en_in && !freeze) begin
            unique case (view_out)
                VIEW_MAX: shown_value_out <= max_val;
                VIEW_MIN: shown_value_out <= min_val;
                default:  shown_value_out <= filtered;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Switch requests
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in) req_out <= '0;
        else if (clk_en_in) begin
            req_out.transmit     <= sw_edge && (cfg_in.fn == transmit_request_fn
                                    || cfg_in.fn == transmit_and_clear_fn);
            req_out.intensity_up <= sw_edge && cfg_in.fn == intensity_step_fn;
            req_out.color_toggle <= sw_edge && cfg_in.fn == backlight_toggle_fn;
            req_out.out1_reset   <= (sw_edge && (cfg_in.fn == OUT1_RESET_FN
                                    || cfg_in.fn == BOTH_OUT_RESET_FN))
                                    || (ui_state_out == ST_DISPLAY && clear_press
                                    && view_out == VIEW_INPUT);
            req_out.out2_reset   <= (sw_edge && (cfg_in.fn == OUT2_RESET_FN
                                    || cfg_in.fn == BOTH_OUT_RESET_FN))
                                    || (ui_state_out == ST_DISPLAY && clear_press
                                    && view_out == VIEW_INPUT);
        end
    end

    // ------------------------------------------------------------
    // Programming menu
    // ------------------------------------------------------------
    logic [31:0] hold_cnt, rep_cnt, blink_cnt;
    logic        locked, hold_done, rep_tick;
    assign locked    = cfg_in.locked || (cfg_in.fn == LOCK_FN && sw_active);
    assign hold_done = hold_cnt == 32'(HOLD_CYC - 1);
    assign rep_tick  = stable[1] && rep_cnt >= 32'(REP_CYC - 1);
    // Parameter 0 of each module is treated as numeric, the rest as selections
    assign edit_numeric_in_unused_out = param_out == 4'h0;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            hold_cnt  <= 32'h0;
            rep_cnt   <= 32'h0;
            blink_cnt <= 32'h0;
            prompt_phase_out <= 1'b0;
        end else if (clk_en_in) begin
            hold_cnt <= (stable[0] && !hold_done) ? hold_cnt + 32'h1
                        : (stable[0] ? hold_cnt : 32'h0);
            rep_cnt  <= (stable[1] && !rep_tick && !clear_press) ? rep_cnt + 32'h1 : 32'h0;
            if (blink_cnt >= 32'(BLK_CYC - 1)) begin
                blink_cnt        <= 32'h0;
                prompt_phase_out <= ~prompt_phase_out;
            end else begin
                blink_cnt <= blink_cnt + 32'h1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ui_state_out    <= ST_DISPLAY;
            module_out      <= 4'h0;
            param_out       <= 4'h0;
            digit_out       <= 3'h0;
            digit_step_out  <= 1'b0;
            choice_step_out <= 1'b0;
            store_out       <= 1'b0;
            commit_out      <= 1'b0;
        end else if (clk_en_in) begin
            digit_step_out  <= 1'b0;
            choice_step_out <= 1'b0;
            store_out       <= 1'b0;
            commit_out      <= 1'b0;
            unique case (ui_state_out)
                ST_DISPLAY: if (hold_cnt == 32'(HOLD_CYC - 2) && !locked) begin
                    ui_state_out <= ST_MENU;
                    module_out   <= 4'h0;
                end
                ST_MENU: begin
                    if (clear_press) begin
                        module_out <= (module_out == NUM_MODULES) ? 4'h0
                                      : module_out + 4'h1;
                    end else if (choose_press) begin
                        if (module_out == 4'h0) begin
                            commit_out   <= 1'b1;
                            ui_state_out <= ST_DISPLAY;
                        end else begin
                            ui_state_out <= ST_PARAM;
                            param_out    <= 4'h0;
                        end
                    end
                end
                ST_PARAM: begin
                    if (clear_press) begin
                        if (param_out == 4'h0) begin
                            ui_state_out <= ST_EDIT;
                            digit_out    <= 3'h0;
                        end else begin
                            choice_step_out <= 1'b1;
                        end
                    end else if (choose_press) begin
                        store_out <= 1'b1;
                        if (param_out == NUM_PARAMS - 4'h1) ui_state_out <= ST_MENU;
                        else param_out <= param_out + 4'h1;
                    end
                end
                ST_EDIT: begin
                    if (clear_press || rep_tick) begin
                        digit_step_out <= 1'b1;
                    end else if (choose_press) begin
                        if (digit_out == 3'(DIGIT_COUNT - 4'h1)) begin
                            store_out    <= 1'b1;
                            ui_state_out <= ST_PARAM;
                            param_out    <= param_out + 4'h1;
                        end else begin
                            digit_out <= digit_out + 3'h1;
                        end
                    end
                end
            endcase
        end
    end

endmodule

// *** tb/meter_ui_keys.sv ***
// Purpose: Operator model: two front keys and the user switch.
// Assumes: Keys high while pressed; switch pulled up, low when closed.
// Notes:   Levels change at falling edges; a quiet gap follows each release.
`timescale 1ns/1ns
module meter_ui_keys #(
    parameter int GAP = 12
) (
    input  wire logic clk_in,
    output logic      choose_out,
    output logic      clear_out,
    output logic      switch_n_out
);
    // Idle: keys up, switch open so the pull-up keeps it high
    initial {switch_n_out, clear_out, choose_out} = 3'b100;
    // Mask is switch, clear, choose; the gap keeps presses apart for the debouncer
    task automatic press(input logic [2:0] m, input int n);
        @(negedge clk_in);
        {switch_n_out, clear_out, choose_out} = {~m[2], m[1:0]};
        repeat (n) @(negedge clk_in);
        {switch_n_out, clear_out, choose_out} = 3'b100;
        repeat (GAP) @(negedge clk_in);
    endtask
endmodule

// *** tb/meter_ui_props.sv ***
// Purpose: Port assertions for the meter operator interface.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Bound to the design at the foot of this file.
`timescale 1ns/1ns
module meter_ui_props
    import meter_ui_pkg::*;
(
    input wire logic      clk_in,
    input wire logic      reset_in,
    input wire logic      external_switch_pin_n_in,
    input wire cfg_t      cfg_in,
    input wire ui_state_t ui_state_out,
    input wire logic      store_out,
    input wire logic      commit_out,
    input wire req_t      req_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    a_commit_single: assert property (commit_out |=> !commit_out)
        else $error("commit longer than one cycle");
    a_commit_exits: assert property (commit_out |-> ##[0:1] ui_state_out == ST_DISPLAY)
        else $error("commit without return to display");
    a_lock_blocks: assert property (cfg_in.locked && ui_state_out == ST_DISPLAY
        |=> ui_state_out == ST_DISPLAY) else $error("menu opened while locked");
    a_transmit_fn: assert property (req_out.transmit
        |-> cfg_in.fn inside {transmit_request_fn, transmit_and_clear_fn})
        else $error("transmit under wrong function");
    a_intensity_fn: assert property (req_out.intensity_up |-> cfg_in.fn == intensity_step_fn)
        else $error("intensity step under wrong function");
    a_color_fn: assert property (req_out.color_toggle |-> cfg_in.fn == backlight_toggle_fn)
        else $error("colour toggle under wrong function");
    a_store_param: assert property (store_out |-> $past(ui_state_out) inside {ST_PARAM, ST_EDIT})
        else $error("store outside parameter walk");
    a_switch_idle: assert property (external_switch_pin_n_in [*8]
        |-> !req_out.intensity_up && !req_out.color_toggle) else $error("action from open switch");
endmodule
bind meter_operator_interface meter_ui_props u_props (
    .clk_in, .reset_in, .external_switch_pin_n_in, .cfg_in, .ui_state_out, .store_out,
    .commit_out, .req_out
);

// *** tb/tb.sv ***
// Purpose: Self-checking bench for the meter operator interface.
// Assumes: Short timing parameters; keys and switch come from meter_ui_keys.
// Notes:   Drivers note expected event words; a monitor pops and compares them.
`timescale 1ns/1ns
module tb;
    import meter_ui_pkg::*;
    localparam int DEB = 4;
    localparam int HOLD = 40;
    localparam int SCR = 60;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic choose_key_in, clear_key_in, external_switch_pin_n_in, reading_valid_in, store_out;
    logic signed [19:0] reading_in, shown_value_out;
    cfg_t cfg_in;
    view_t view_out;
    ui_state_t ui_state_out;
    logic [3:0] module_out, param_out;
    logic digit_step_out, choice_step_out, commit_out, load_defaults_out, reset_msg_out;
    logic clk_en_in = 1'b1, prompt_phase_out, p;
    logic [2:0] digit_out;
    req_t req_out;
    logic [9:0] exp_q[$];
    int bad_count = 0;
    int num_checks = 0;
    switch_fn_t fns[8] = '{intensity_step_fn, backlight_toggle_fn, transmit_request_fn,
        transmit_and_clear_fn, OUT1_RESET_FN, OUT2_RESET_FN, BOTH_OUT_RESET_FN, view_advance_fn};
    logic [4:0] rq[8] = '{5'h02, 5'h01, 5'h04, 5'h04, 5'h10, 5'h08, 5'h18, 5'h00};
    logic [1:0] lv[5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
    logic [7:0] bd[5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h32};
    logic [19:0] tg[5] = '{20'h064, 20'h1f4, 20'h3e8, 20'h76c, 20'h3e8};
    logic [19:0] xp[5] = '{20'h064, 20'h0c8, 20'h12c, 20'h190, 20'h3e8};
    wire [9:0] ev = {load_defaults_out, commit_out, store_out, digit_step_out, choice_step_out,
        req_out};

    // Small counts keep the run short
    meter_operator_interface #(.HOLD_CYC(HOLD), .SCROLL_P(SCR), .DEB_CYC(DEB),
        .BLK_CYC(16)) uut (
        .clk_in, .reset_in, .clk_en_in, .choose_key_in, .clear_key_in,
        .external_switch_pin_n_in, .cfg_in, .reading_valid_in, .reading_in, .shown_value_out,
        .view_out, .ui_state_out, .prompt_phase_out, .module_out, .param_out, .digit_out,
        .digit_step_out, .choice_step_out, .store_out, .commit_out, .load_defaults_out,
        .reset_msg_out, .edit_numeric_in_unused_out(), .req_out);
    meter_ui_keys keys (.clk_in, .choose_out(choose_key_in),
        .clear_out(clear_key_in), .switch_n_out(external_switch_pin_n_in));

    initial forever #5 clk_in = ~clk_in;

    task automatic check(input string nm, input logic [19:0] e, input logic [19:0] s);
        num_checks++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Each event word pops the oldest note; an unnoted one is a mismatch
    always @(negedge clk_in) begin
        if (!reset_in && ev !== 10'h000) begin
            if (exp_q.size() == 0) check("event", 20'h00000, 20'(ev));
            else check("event", 20'(exp_q.pop_front()), 20'(ev));
        end
    end

    // Hang guard: a stuck run still ends in the verdict
    initial begin
        #500000;
        bad_count++;
        complete_run();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(70));
        reading_valid_in = 1'b0;
        reading_in = 20'sh00000;
        cfg_in = '0;
        cfg_in.max_en = 1'b1;
        cfg_in.min_en = 1'b1;
        exp_q.push_back(10'h200);
        fork
            keys.press(3'b011, DEB + 10);
            begin repeat (4) @(negedge clk_in); reset_in = 1'b0; end
        join
        check("reset_msg", 20'h00001, 20'(reset_msg_out));
        for (int i = 0; i < 3; i++) begin
            keys.press(3'b001, DEB + 4);
            check("view", 20'((i + 1) % 3), 20'(view_out));
        end
        exp_q.push_back(10'h018);
        keys.press(3'b010, DEB + 4);
        for (int i = 0; i < 8; i++) begin
            cfg_in.fn = fns[i];
            if (rq[i] !== 5'h00) exp_q.push_back({5'h00, rq[i]});
            keys.press(3'b100, DEB + 4 + int'($urandom % 8));
        end
        check("advance", 20'(VIEW_MAX), 20'(view_out));
        repeat (2) keys.press(3'b001, DEB + 4);
        p = prompt_phase_out;
        clk_en_in = 1'b0;
        keys.press(3'b001, DEB + 4);
        clk_en_in = 1'b1;
        check("frozen", 20'(p), 20'(prompt_phase_out));
        cfg_in.fn = NO_FN;
        cfg_in.offset = 20'(16 * int'($urandom % 200) - 1600);
        for (int i = 0; i < 5; i++) begin
            cfg_in.filter_level = lv[i];
            cfg_in.filter_band = bd[i];
            @(negedge clk_in);
            reading_in = tg[i] - cfg_in.offset;
            reading_valid_in = 1'b1;
            @(negedge clk_in);
            reading_valid_in = 1'b0;
            for (int k = 0; k < 12 && shown_value_out !== xp[i]; k++) @(negedge clk_in);
            check("shown", xp[i], shown_value_out);
        end
        cfg_in.scroll_en = 1'b1;
        for (int k = 0; k < SCR + 8 && view_out === VIEW_INPUT; k++) @(negedge clk_in);
        check("scroll", 20'(VIEW_MAX), 20'(view_out));
        cfg_in.scroll_en = 1'b0;
        cfg_in.locked = 1'b1;
        keys.press(3'b001, HOLD + DEB + 8);
        check("locked", 20'(ST_DISPLAY), 20'(ui_state_out));
        cfg_in.locked = 1'b0;
        keys.press(3'b001, HOLD + DEB + 8);
        check("menu", 20'(ST_MENU), 20'(ui_state_out));
        keys.press(3'b010, DEB + 4);
        check("module", 20'h00001, 20'(module_out));
        keys.press(3'b001, DEB + 4);
        check("param", 20'(ST_PARAM), 20'(ui_state_out));
        keys.press(3'b010, DEB + 4);
        check("edit", 20'(ST_EDIT), 20'(ui_state_out));
        exp_q.push_back(10'h040);
        keys.press(3'b010, DEB + 4);
        exp_q.push_back(10'h080);
        repeat (5) keys.press(3'b001, DEB + 4);
        check("digit", 20'(DIGIT_COUNT - 1), 20'(digit_out));
        exp_q.push_back(10'h020);
        keys.press(3'b010, DEB + 4);
        repeat (3) exp_q.push_back(10'h080);
        repeat (3) keys.press(3'b001, DEB + 4);
        check("back", 20'(ST_MENU), 20'(ui_state_out));
        for (int k = 0; k < 6 && module_out !== 4'h0; k++) keys.press(3'b010, DEB + 4);
        exp_q.push_back(10'h100);
        keys.press(3'b001, DEB + 4);
        check("exit", 20'(ST_DISPLAY), 20'(ui_state_out));
        check("queue", 20'h00000, 20'(exp_q.size()));
        complete_run();
    end
endmodule
